//--- src/cxc_exc_ctrl.sv
// Purpose: exception, break and interrupt sequencing for a soft core
// Assumes: core presents one retiring instruction per cycle via strobes
// Notes: vectors are parameters fixed at build time
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Service order: reset, hardware break, core reset, interrupt, instruction events.
// - Processor reset clears the whole status register to zero.
// - During reset invalidate reset-vector cache line, then fetch at reset vector.
// - Other state needs no reset; general register zero always reads zero.
// - Break entered by break instruction or debug hardware-break request.
// - Break saves status, clears enable, writes next address to r30, vectors.
// - Break vector is build constant; break accepted inside exception handlers.
// - Break return restores saved status and jumps to r30.
// - Interrupt taken only if enable set and some unmasked request high.
// - Taking an interrupt clears the global interrupt enable.
// - Software writing enable one re-enables interrupts, allowing nesting.
// - Instruction exceptions are precise; faulting instruction commits nothing.
// - Trap instruction raises an exception through the general vector.
// - Break instruction uses the break vector, not the general one.
// - Unimplemented valid instruction raises exception through general vector.
// - Illegal instruction words are left undefined, not trapped.
// - Exception saves status, clears enable, writes next address to r29.
// - General exception vector is a build constant, not writable.
// - Interrupt identified by saved enable one and pending nonzero.
// - Pending register shows live request levels; writes ignored.
// - Exception return restores saved status and jumps to r29.
module cxc_exc_ctrl
  import cxc_pkg::*;
#(
  parameter int NIRQ = 32,
  parameter logic [31:0] RESET_VEC = 32'h0000_0000,
  parameter logic [31:0] EXC_VEC = 32'h0000_0020,
  parameter logic [31:0] BRK_VEC = 32'h0000_0100,
  // Arbitrary value, identifies this core instance
  parameter logic [31:0] CORE_ID = 32'h0000_0001
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Core instruction retire strobes
  input wire logic insn_valid,
  input wire logic [31:0] insn_pc,
  input wire logic insn_trap,
  input wire logic insn_break,
  input wire logic insn_unimp,
  input wire logic insn_eret,
  input wire logic insn_bret,
  input wire logic [31:0] gpr_exc_rd,
  input wire logic [31:0] gpr_brk_rd,
  // External requests
  input wire logic [NIRQ-1:0] irq,
  input wire logic dbg_break_req,
  input wire logic core_reset_req,
  // Core redirect and register write
  output logic redirect,
  output logic [31:0] redirect_pc,
  output logic insn_commit,
  output logic gpr_we,
  output logic [4:0] gpr_waddr,
  output logic [31:0] gpr_wdata,
  output logic icache_inval,
  output logic [31:0] icache_inval_addr,
  output logic global_irq_enable
);
  initial begin
    if (NIRQ < 1 || NIRQ > 32) $error("NIRQ must be 1..32");
  end

  typedef struct packed {
    cxc_state_t st;
    logic [NIRQ-1:0] irq_s1;
    logic [NIRQ-1:0] irq_s2;
    logic dbg_s1;
    logic dbg_s2;
    logic crr_s1;
    logic crr_s2;
    logic global_irq_enable;
    logic saved_irq_enable_exc;
    logic saved_irq_enable_brk;
    logic [NIRQ-1:0] ienable;
    cxc_cause_t cause;
    logic [31:0] exception_return_addr;
    logic [31:0] break_return_addr;
    logic redirect;
    logic [31:0] redirect_pc;
    logic commit;
    logic gpr_we;
    logic [4:0] gpr_waddr;
    logic [31:0] gpr_wdata;
    logic inval;
    logic [31:0] prdata;
  } cxc_regs_t;

  cxc_regs_t r_q, r_d;
  logic apb_wr, apb_rd, unmapped;
  logic [NIRQ-1:0] pending;
  logic irq_due;
  cxc_cause_t take;

  function automatic logic is_mapped(input logic [11:0] a);
    is_mapped = (a == CXC_OFF_STATUS) || (a == CXC_OFF_ESTATUS) ||
      (a == CXC_OFF_BSTATUS) || (a == CXC_OFF_IENABLE) ||
      (a == CXC_OFF_IPENDING) || (a == CXC_OFF_CPUID) ||
      (a == CXC_OFF_CAUSE) || (a == CXC_OFF_EPC) || (a == CXC_OFF_BPC);
  endfunction

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;
  assign unmapped = !is_mapped(paddr);
  assign pending = r_q.irq_s2;
  assign irq_due = r_q.global_irq_enable && |(pending & r_q.ienable);

  // Fixed priority pick; only one cause per cycle
  always_comb begin
    take = CXC_C_NONE;
    if (r_q.dbg_s2) begin
      take = CXC_C_HWBRK;
    end else if (r_q.crr_s2) begin
      take = CXC_C_CORERST;
    end else if (irq_due) begin
      take = CXC_C_IRQ;
    end else if (insn_valid && insn_break) begin
      take = CXC_C_SWBRK;
    end else if (insn_valid && insn_trap) begin
      take = CXC_C_TRAP;
    end else if (insn_valid && insn_unimp) begin
      take = CXC_C_UNIMP;
    end
  end

  always_comb begin
    r_d = r_q;
    r_d.irq_s1 = irq;
    r_d.irq_s2 = r_q.irq_s1;
    r_d.dbg_s1 = dbg_break_req;
    r_d.dbg_s2 = r_q.dbg_s1;
    r_d.crr_s1 = core_reset_req;
    r_d.crr_s2 = r_q.crr_s1;
    r_d.redirect = 1'b0;
    r_d.commit = 1'b0;
    r_d.gpr_we = 1'b0;
    r_d.inval = 1'b0;
    // Register writes first; entry sequences below override status
    if (apb_wr) begin
      if (paddr == CXC_OFF_STATUS) begin
        r_d.global_irq_enable = pwdata[CXC_IRQ_BIT];
      end else if (paddr == CXC_OFF_ESTATUS) begin
        r_d.saved_irq_enable_exc = pwdata[CXC_IRQ_BIT];
      end else if (paddr == CXC_OFF_BSTATUS) begin
        r_d.saved_irq_enable_brk = pwdata[CXC_IRQ_BIT];
      end else if (paddr == CXC_OFF_IENABLE) begin
        r_d.ienable = pwdata[NIRQ-1:0];
      end
    end
    if (apb_rd) begin
      if (paddr == CXC_OFF_STATUS) begin
        r_d.prdata = {31'h0, r_q.global_irq_enable};
      end else if (paddr == CXC_OFF_ESTATUS) begin
        r_d.prdata = {31'h0, r_q.saved_irq_enable_exc};
      end else if (paddr == CXC_OFF_BSTATUS) begin
        r_d.prdata = {31'h0, r_q.saved_irq_enable_brk};
      end else if (paddr == CXC_OFF_IENABLE) begin
        r_d.prdata = 32'(r_q.ienable);
      end else if (paddr == CXC_OFF_IPENDING) begin
        r_d.prdata = 32'(pending);
      end else if (paddr == CXC_OFF_CPUID) begin
        r_d.prdata = CORE_ID;
      end else if (paddr == CXC_OFF_CAUSE) begin
        r_d.prdata = {29'h0, r_q.cause};
      end else if (paddr == CXC_OFF_EPC) begin
        r_d.prdata = r_q.exception_return_addr;
      end else if (paddr == CXC_OFF_BPC) begin
        r_d.prdata = r_q.break_return_addr;
      end else begin
        r_d.prdata = 32'h0000_0000;
      end
    end
    case (r_q.st)
      CXC_S_RESET: begin
        // Fetch begins only after the reset line is invalidated
        r_d.global_irq_enable = 1'b0;
        r_d.redirect = 1'b1;
        r_d.redirect_pc = RESET_VEC;
        r_d.cause = CXC_C_RESET;
        r_d.st = CXC_S_RUN;
      end
      CXC_S_RUN, CXC_S_EXC, CXC_S_BRK: begin
        r_d.st = CXC_S_RUN;
        // Exception entry: faulting instruction never commits
        case (take)
          CXC_C_HWBRK, CXC_C_SWBRK: begin
            r_d.saved_irq_enable_brk = r_q.global_irq_enable;
            r_d.global_irq_enable = 1'b0;
            r_d.gpr_we = 1'b1;
            r_d.gpr_waddr = CXC_GPR_BRK;
            r_d.gpr_wdata = insn_pc + CXC_INSN_BYTES;
            r_d.break_return_addr = insn_pc + CXC_INSN_BYTES;
            r_d.redirect = 1'b1;
            r_d.redirect_pc = BRK_VEC;
            r_d.cause = take;
            r_d.st = CXC_S_BRK;
          end
          CXC_C_CORERST: begin
            r_d.st = CXC_S_RESET;
            r_d.inval = 1'b1;
            r_d.global_irq_enable = 1'b0;
          end
          CXC_C_IRQ, CXC_C_TRAP, CXC_C_UNIMP: begin
            r_d.saved_irq_enable_exc = r_q.global_irq_enable;
            r_d.global_irq_enable = 1'b0;
            r_d.gpr_we = 1'b1;
            r_d.gpr_waddr = CXC_GPR_EXC;
            r_d.gpr_wdata = insn_pc + CXC_INSN_BYTES;
            r_d.exception_return_addr = insn_pc + CXC_INSN_BYTES;
            r_d.redirect = 1'b1;
            r_d.redirect_pc = EXC_VEC;
            r_d.cause = take;
            r_d.st = CXC_S_EXC;
          end
          default: begin
            // Illegal words are not trapped here
            if (insn_valid && insn_eret) begin
              r_d.global_irq_enable = r_q.saved_irq_enable_exc;
              r_d.redirect = 1'b1;
              r_d.redirect_pc = gpr_exc_rd;
            end else if (insn_valid && insn_bret) begin
              r_d.global_irq_enable = r_q.saved_irq_enable_brk;
              r_d.redirect = 1'b1;
              r_d.redirect_pc = gpr_brk_rd;
            end else begin
              r_d.commit = insn_valid;
            end
          end
        endcase
      end
      default: r_d.st = CXC_S_RESET;
    endcase
  end

  // Only constants under reset; r0 stays zero in the register file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r_q <= '0;
      r_q.st <= CXC_S_RESET;
      r_q.global_irq_enable <= CXC_STATUS_RST[CXC_IRQ_BIT];
      r_q.inval <= 1'b1;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata = r_q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && unmapped;
  assign redirect = r_q.redirect;
  assign redirect_pc = r_q.redirect_pc;
  assign insn_commit = r_q.commit;
  assign gpr_we = r_q.gpr_we;
  assign gpr_waddr = r_q.gpr_waddr;
  assign gpr_wdata = r_q.gpr_wdata;
  assign icache_inval = r_q.inval;
  assign icache_inval_addr = RESET_VEC;
  assign global_irq_enable = r_q.global_irq_enable;

  property p_irq_clears_enable;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st != CXC_S_RESET && take == CXC_C_IRQ)
        |=> (!global_irq_enable && r_q.saved_irq_enable_exc && redirect
             && redirect_pc == EXC_VEC && gpr_waddr == CXC_GPR_EXC);
  endproperty
  a_irq_clears_enable: assert property (p_irq_clears_enable)
    else $error("interrupt entry wrong");

  property p_irq_gate;
    @(posedge pclk) disable iff (!presetn)
      (redirect && gpr_we && redirect_pc == EXC_VEC &&
        r_q.cause == CXC_C_IRQ)
        |-> ($past(global_irq_enable) && $past(|(r_q.irq_s2 & r_q.ienable)));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt taken while gated");

  property p_brk_entry;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st != CXC_S_RESET && (take == CXC_C_HWBRK || take == CXC_C_SWBRK))
        |=> (redirect && redirect_pc == BRK_VEC && gpr_we
             && gpr_waddr == CXC_GPR_BRK && !global_irq_enable);
  endproperty
  a_brk_entry: assert property (p_brk_entry)
    else $error("break entry wrong");

  property p_hwbrk_first;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st != CXC_S_RESET && r_q.dbg_s2) |=> (redirect &&
        redirect_pc == BRK_VEC && r_q.cause == CXC_C_HWBRK);
  endproperty
  a_hwbrk_first: assert property (p_hwbrk_first)
    else $error("hardware break lost priority");

  property p_reset_seq;
    @(posedge pclk) disable iff (!presetn)
      (presetn && r_q.st == CXC_S_RESET) |=> (redirect
        && redirect_pc == RESET_VEC
        && !global_irq_enable);
  endproperty
  a_reset_seq: assert property (p_reset_seq)
    else $error("reset sequence wrong");

  property p_no_commit_on_exc;
    @(posedge pclk) disable iff (!presetn)
      (take != CXC_C_NONE) |=> !insn_commit;
  endproperty
  a_no_commit_on_exc: assert property (p_no_commit_on_exc)
    else $error("faulting instruction committed");

  property p_eret;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st != CXC_S_RESET && take == CXC_C_NONE && insn_valid && insn_eret)
        |=> (redirect && redirect_pc == $past(gpr_exc_rd)
             && global_irq_enable == $past(r_q.saved_irq_enable_exc));
  endproperty
  a_eret: assert property (p_eret)
    else $error("exception return wrong");

  property p_trap_vec;
    @(posedge pclk) disable iff (!presetn)
      (r_q.st != CXC_S_RESET && take == CXC_C_TRAP)
        |=> (redirect_pc == EXC_VEC && gpr_wdata == $past(insn_pc) + 32'h4);
  endproperty
  a_trap_vec: assert property (p_trap_vec)
    else $error("trap entry wrong");
endmodule
`default_nettype wire

//--- src/cxc_pkg.sv
// Purpose: constants for the exception sequencing block
// Assumes: 32-bit data, APB register access
// Notes: control registers live at word offsets below
package cxc_pkg;
  localparam logic [11:0] CXC_OFF_STATUS = 12'h000;
  localparam logic [11:0] CXC_OFF_ESTATUS = 12'h004;
  localparam logic [11:0] CXC_OFF_BSTATUS = 12'h008;
  localparam logic [11:0] CXC_OFF_IENABLE = 12'h00C;
  localparam logic [11:0] CXC_OFF_IPENDING = 12'h010;
  localparam logic [11:0] CXC_OFF_CPUID = 12'h014;
  localparam logic [11:0] CXC_OFF_CAUSE = 12'h018;
  localparam logic [11:0] CXC_OFF_EPC = 12'h01C;
  localparam logic [11:0] CXC_OFF_BPC = 12'h020;
  localparam int CXC_IRQ_BIT = 0;
  localparam logic [31:0] CXC_STATUS_RST = 32'h0000_0000;
  localparam logic [31:0] CXC_INSN_BYTES = 32'h0000_0004;
  localparam logic [4:0] CXC_GPR_EXC = 5'h1D;
  localparam logic [4:0] CXC_GPR_BRK = 5'h1E;
  typedef enum logic [2:0] {
    CXC_C_NONE = 3'h0,
    CXC_C_RESET = 3'h1,
    CXC_C_HWBRK = 3'h2,
    CXC_C_CORERST = 3'h3,
    CXC_C_IRQ = 3'h4,
    CXC_C_TRAP = 3'h5,
    CXC_C_SWBRK = 3'h6,
    CXC_C_UNIMP = 3'h7
  } cxc_cause_t;
  typedef enum logic [3:0] {
    CXC_S_RESET = 4'b0001,
    CXC_S_RUN = 4'b0010,
    CXC_S_EXC = 4'b0100,
    CXC_S_BRK = 4'b1000
  } cxc_state_t;
endpackage

//--- test/cxc_far_model.sv
// Purpose: interrupt sources and debug module on the far side
// Assumes: same clock as the block
// Notes: interrupt requests stay up until the bench acknowledges them; debug break follows brk_want
`timescale 1ns/1ns
`default_nettype none
module cxc_far_model (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench controls
  input wire logic [31:0] raise,
  input wire logic [31:0] ack,
  input wire logic brk_want,
  // Requests into the block
  output logic [31:0] irq,
  output logic dbg_break_req
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 32'h0000_0000;
      dbg_break_req <= 1'b0;
    end else begin
      // Never dropped before service, so a slow handler still sees it
      irq <= (irq | raise) & ~ack;
      dbg_break_req <= brk_want;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_cxc_exc_ctrl.sv
// Purpose: self-checking bench for the exception sequencing block
// Assumes: zero wait APB; outputs one edge after a retiring instruction
// Notes: requests cross a two flop sync, so waits are bounded
`timescale 1ns/1ns
`default_nettype none
module tb_cxc_exc_ctrl;
  import cxc_pkg::*;
  localparam logic [31:0] EV = 32'h0000_0020;
  localparam logic [31:0] BV = 32'h0000_0100;
  localparam logic [31:0] RV = 32'h0000_0000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, insn_pc, gpr_exc_rd, gpr_brk_rd, hit_pc;
  logic [31:0] irq, raise, ack, redirect_pc, gpr_wdata, icache_inval_addr;
  logic [4:0] kind, gpr_waddr;
  logic insn_valid, dbg_break_req, core_reset_req, brk_want, redirect;
  logic insn_commit, gpr_we, icache_inval, global_irq_enable, seen, hit;
  wire logic insn_trap, insn_break, insn_unimp, insn_eret, insn_bret;
  int errors, num_checks, cycles;
  // Kind order: trap, break, unimp, eret, bret
  assign {insn_trap, insn_break, insn_unimp, insn_eret, insn_bret} = kind;
  cxc_exc_ctrl #(.NIRQ(32), .RESET_VEC(RV), .EXC_VEC(EV), .BRK_VEC(BV),
    .CORE_ID(32'h0000_0001)) cxc_exc_ctrl_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .insn_valid(insn_valid),
    .insn_pc(insn_pc), .insn_trap(insn_trap), .insn_break(insn_break),
    .insn_unimp(insn_unimp), .insn_eret(insn_eret), .insn_bret(insn_bret),
    .gpr_exc_rd(gpr_exc_rd), .gpr_brk_rd(gpr_brk_rd), .irq(irq),
    .dbg_break_req(dbg_break_req), .core_reset_req(core_reset_req),
    .redirect(redirect), .redirect_pc(redirect_pc),
    .insn_commit(insn_commit), .gpr_we(gpr_we), .gpr_waddr(gpr_waddr),
    .gpr_wdata(gpr_wdata), .icache_inval(icache_inval),
    .icache_inval_addr(icache_inval_addr),
    .global_irq_enable(global_irq_enable));
  cxc_far_model cxc_far_model_inst (.pclk(pclk), .presetn(presetn),
    .raise(raise), .ack(ack), .brk_want(brk_want), .irq(irq),
    .dbg_break_req(dbg_break_req));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Pulses may land between instructions, so catch them mid-cycle
  always @(negedge pclk) begin
    cycles++;
    if (icache_inval === 1'b1) seen = 1'b1;
    if (redirect === 1'b1) begin
      hit = 1'b1;
      hit_pc = redirect_pc;
    end
    if (cycles == 5000) begin
      errors++;
      results();
    end
  end
  function automatic logic [31:0] z(input logic x);
    return {31'h0, x};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rd, e);
  endtask
  task automatic pulse(input logic [31:0] r, input logic [31:0] a);
    @(posedge pclk);
    raise <= r;
    ack <= a;
    @(posedge pclk);
    raise <= 32'h0;
    ack <= 32'h0;
    repeat (4) @(posedge pclk);
  endtask
  // Starts in this step, so it meets the edge after a status write
  task automatic go(input logic [4:0] k, input logic [31:0] pc);
    insn_valid <= 1'b1;
    kind <= k;
    insn_pc <= pc;
    @(posedge pclk);
    insn_valid <= 1'b0;
    kind <= 5'h00;
    #1;
  endtask
  task automatic ins(input logic [4:0] k, input logic [31:0] pc);
    @(posedge pclk);
    go(k, pc);
  endtask
  task automatic pl(input logic [31:0] pc);
    ins(5'h00, pc);
    chk(z(redirect), 32'h0);
    chk(z(insn_commit), 32'h1);
  endtask
  task automatic ent(input logic [31:0] pc, input logic [4:0] wa,
    input logic [31:0] wd, input logic en);
    chk(z(redirect), 32'h1);
    chk(redirect_pc, pc);
    chk(z(gpr_we), z(wa != 5'h00));
    if (wa != 5'h00) begin
      chk({27'h0, gpr_waddr}, {27'h0, wa});
      chk(gpr_wdata, wd);
      chk(z(insn_commit), 32'h0);
    end
    chk(z(global_irq_enable), z(en));
  endtask
  initial begin
    {presetn, psel, penable, pwrite, insn_valid, brk_want} = 6'h00;
    {core_reset_req, slv, seen, hit, kind, paddr} = 21'h000000;
    {pwdata, insn_pc, gpr_exc_rd, gpr_brk_rd, raise, ack} = '0;
    repeat (12) @(posedge pclk);
    #1;
    chk(z(icache_inval), 32'h1);
    chk(icache_inval_addr, RV);
    chk(z(global_irq_enable), 32'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    ent(RV, 5'h00, 32'h0, 1'b0);
    rchk(CXC_OFF_STATUS, 32'h0);
    rchk(12'h100, 32'h0);
    chk(z(slv), 32'h1);
    $display("test reset done");
    apb(1'b1, CXC_OFF_IENABLE, 32'h0);
    apb(1'b1, CXC_OFF_STATUS, 32'h1);
    pulse(32'h20, 32'h0);
    rchk(CXC_OFF_IPENDING, 32'h20);
    apb(1'b1, CXC_OFF_IPENDING, 32'h0);
    rchk(CXC_OFF_IPENDING, 32'h20);
    pl(32'h400);
    apb(1'b1, CXC_OFF_STATUS, 32'h0);
    apb(1'b1, CXC_OFF_IENABLE, 32'h20);
    pl(32'h440);
    apb(1'b1, CXC_OFF_STATUS, 32'h1);
    go(5'h10, 32'h500);
    ent(EV, CXC_GPR_EXC, 32'h504, 1'b0);
    rchk(CXC_OFF_CAUSE, 32'h4);
    rchk(CXC_OFF_ESTATUS, 32'h1);
    apb(1'b1, CXC_OFF_STATUS, 32'h1);
    go(5'h00, 32'h600);
    ent(EV, CXC_GPR_EXC, 32'h604, 1'b0);
    pulse(32'h0, 32'h20);
    gpr_exc_rd <= 32'h604;
    ins(5'h02, 32'h24);
    ent(32'h604, 5'h00, 32'h0, 1'b1);
    $display("test interrupt done");
    ins(5'h10, 32'h700);
    ent(EV, CXC_GPR_EXC, 32'h704, 1'b0);
    rchk(CXC_OFF_CAUSE, 32'h5);
    apb(1'b1, CXC_OFF_STATUS, 32'h1);
    ins(5'h04, 32'h800);
    ent(EV, CXC_GPR_EXC, 32'h804, 1'b0);
    rchk(CXC_OFF_CAUSE, 32'h7);
    pl(32'h900);
    apb(1'b1, CXC_OFF_STATUS, 32'h1);
    ins(5'h08, 32'hA00);
    ent(BV, CXC_GPR_BRK, 32'hA04, 1'b0);
    rchk(CXC_OFF_BSTATUS, 32'h1);
    gpr_brk_rd <= 32'hA04;
    ins(5'h01, 32'h104);
    ent(32'hA04, 5'h00, 32'h0, 1'b1);
    gpr_exc_rd <= 32'h804;
    ins(5'h02, 32'h28);
    ent(32'h804, 5'h00, 32'h0, 1'b1);
    $display("test instruction events done");
    apb(1'b1, CXC_OFF_STATUS, 32'h0);
    @(posedge pclk);
    brk_want <= 1'b1;
    repeat (2) @(posedge pclk);
    ins(5'h10, 32'hB00);
    ent(BV, CXC_GPR_BRK, 32'hB04, 1'b0);
    rchk(CXC_OFF_CAUSE, 32'h2);
    brk_want <= 1'b0;
    repeat (6) @(posedge pclk);
    {seen, hit} = 2'b00;
    core_reset_req <= 1'b1;
    for (int i = 0; i < 8 && hit !== 1'b1; i++) ins(5'h00, 32'hC00);
    chk(z(seen), 32'h1);
    chk(hit_pc, RV);
    core_reset_req <= 1'b0;
    $display("test break and core reset done");
    results();
  end
endmodule
`default_nettype wire
